// file: rtl/lhi_pkg.sv
// Purpose: shared constants and types of the lcd host interface
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   offsets, field positions and reset values live here only

package lhi_pkg;

  // ==========================================================
  // register map
  localparam int          AXI_ADDR_W = 8;
  localparam int          AXI_DATA_W = 32;
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_STAT  = 8'h04;
  localparam logic [7:0]  ADDR_RXD   = 8'h08;
  localparam logic [7:0]  ADDR_RDD   = 8'h0C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // field positions
  localparam int CTRL_BUSY     = 0;
  localparam int STAT_NEMPTY   = 0;
  localparam int STAT_OVF      = 1;
  localparam int STAT_REFUSED  = 2;
  localparam int STAT_STYLE68  = 3;
  localparam int STAT_PARALLEL = 4;
  localparam int STAT_INIT     = 5;
  localparam int RXD_DC        = 8;
  localparam int RXD_VALID     = 31;
  localparam int PIN_SI        = 7;
  localparam int PIN_SCL       = 6;

  // ==========================================================
  // sizes and reset values
  localparam int         BYTE_W      = 8;
  localparam int         FIFO_DEPTH  = 16;
  localparam logic [2:0] SER_LAST    = 3'h7;
  localparam logic [2:0] SER_FIRST   = 3'h0;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [6:0] STATUS_LOW  = 7'h00;

  // ==========================================================
  // types
  typedef struct packed {
    logic             dc;
    logic [BYTE_W-1:0] data;
  } lhi_byte_t;

  typedef struct packed {
    logic             cs_n;
    logic             dcs;
    logic             wr_n;
    logic             rd_n;
    logic             style;
    logic             parallel;
    logic             init_n;
    logic [BYTE_W-1:0] d;
  } lhi_pins_t;

  localparam lhi_pins_t PINS_IDLE = '{cs_n: 1'b1, dcs: 1'b0, wr_n: 1'b1, rd_n: 1'b1,
                                      style: 1'b0, parallel: 1'b1, init_n: 1'b0,
                                      d: 8'h00};

endpackage

// file: rtl/lhi_fifo.sv
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   read data leave from a register; in_ready drops when full

`timescale 1ns/1ps

module lhi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             out_valid_r, out_valid_nxt;
  logic [WIDTH-1:0] out_data_r, out_data_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != CNT_FULL);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  // ==========================================================
  // pointer and output stage
  always_comb begin
    push          = in_valid && in_ready;
    pop           = (cnt_r != '0) && (!out_valid_r || out_ready);
    wr_ptr_nxt    = push ? wr_ptr_r + PTR_W'(1) : wr_ptr_r;
    rd_ptr_nxt    = pop ? rd_ptr_r + PTR_W'(1) : rd_ptr_r;
    cnt_nxt       = cnt_r + CNT_W'(push) - CNT_W'(pop);
    out_valid_nxt = out_valid_r;
    out_data_nxt  = out_data_r;
    if (out_valid_r && out_ready) begin
      out_valid_nxt = 1'b0;
    end
    if (pop) begin
      out_valid_nxt = 1'b1;
      out_data_nxt  = mem[rd_ptr_r];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      cnt_r       <= '0;
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else begin
      wr_ptr_r    <= wr_ptr_nxt;
      rd_ptr_r    <= rd_ptr_nxt;
      cnt_r       <= cnt_nxt;
      out_valid_r <= out_valid_nxt;
      out_data_r  <= out_data_nxt;
    end
  end

  // storage has no reset; content is only read behind cnt_r
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

endmodule

// file: rtl/lhi_host_port.sv
// Purpose: microprocessor port of a bitmap lcd driver, 68/80 parallel or serial
// Assumes: pins are asynchronous to CORE_CLK and slow against 125 MHz
// Notes:   received bytes queue in a fifo drained over AXI4-Lite
//
// Decided for this implementation: the address map and register access over AXI4-Lite.

`timescale 1ns/1ps

// How it works
// - style strap high is 68-style, low 80-style
// - transport strap: high parallel, low serial input
// - serial: shift on clock rise, latch at 8th
// - serial data top pin, clock pin below it
// - serial mode never drives reads or status
// - serial: strobes ignored, low pins stay undriven
// - select high marks display data, low instruction
// - transfers only while chip select is low
// - init pin low blocks all pin transfers and reads
// - 80-style read strobe low drives all eight pins
// - 80-style write captures at strobe rising edge
// - 68-style enable high, direction high reads
// - busy refuses instructions, status shows busy top bit
// - init pin clears serial shift register
module lhi_host_port (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // host pins
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        DATA_COMMAND_SELECT,
  input  wire logic        WRITE_STROBE_N,
  input  wire logic        READ_STROBE_N,
  input  wire logic        BUS_STYLE_SELECT,
  input  wire logic        PARALLEL_SELECT,
  input  wire logic        HARD_INIT_N,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic      [7:0]  DATA_OE_N,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == lhi_pkg::ADDR_CTRL) || (a == lhi_pkg::ADDR_STAT) ||
              (a == lhi_pkg::ADDR_RXD)  || (a == lhi_pkg::ADDR_RDD);
  endfunction

  // ==========================================================
  // pin synchronisers
  lhi_pkg::lhi_pins_t pin_raw, pin_s1_r, pin_s2_r, pin_q_r;

  assign pin_raw = '{cs_n: CHIP_SELECT_N, dcs: DATA_COMMAND_SELECT, wr_n: WRITE_STROBE_N,
                     rd_n: READ_STROBE_N, style: BUS_STYLE_SELECT,
                     parallel: PARALLEL_SELECT, init_n: HARD_INIT_N, d: DATA_IN};

  // pin_q_r keeps the previous synced sample for edge detection
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_s1_r <= lhi_pkg::PINS_IDLE;
      pin_s2_r <= lhi_pkg::PINS_IDLE;
      pin_q_r  <= lhi_pkg::PINS_IDLE;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_q_r  <= pin_s2_r;
    end
  end

  // ==========================================================
  // strobe decoding
  logic in_init, style68, parallel, sel_now, sel_prev;
  logic wr80_edge, wr68_edge, scl_rise, read_active;

  always_comb begin
    in_init   = !pin_s2_r.init_n;
    style68   = pin_s2_r.style;
    parallel  = pin_s2_r.parallel;
    sel_now   = !pin_s2_r.cs_n && !in_init;
    sel_prev  = !pin_q_r.cs_n && !in_init;
    wr80_edge = parallel && !style68 && sel_prev &&
                !pin_q_r.wr_n && pin_s2_r.wr_n;
    // 68-style write ends on the falling edge of the enable
    wr68_edge = parallel && style68 && sel_prev && !pin_q_r.wr_n &&
                pin_q_r.rd_n && !pin_s2_r.rd_n;
    // strobe pins are not looked at in serial mode
    scl_rise  = !parallel && sel_now && !pin_q_r.d[lhi_pkg::PIN_SCL] &&
                pin_s2_r.d[lhi_pkg::PIN_SCL];
    read_active = parallel && sel_now &&
                  (style68 ? (pin_s2_r.rd_n && pin_s2_r.wr_n)
                           : !pin_s2_r.rd_n);
  end

  // ==========================================================
  // serial shifter and byte capture
  logic [6:0]         shift_r, shift_nxt;
  logic [2:0]         bit_cnt_r, bit_cnt_nxt;
  lhi_pkg::lhi_byte_t new_byte;
  logic               new_valid;

  always_comb begin
    shift_nxt   = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    new_valid   = 1'b0;
    new_byte    = '{dc: pin_q_r.dcs, data: pin_q_r.d};
    if (wr80_edge || wr68_edge) begin
      new_valid = 1'b1;
    end
    if (scl_rise) begin
      shift_nxt   = {shift_r[5:0], pin_s2_r.d[lhi_pkg::PIN_SI]};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == lhi_pkg::SER_LAST) begin
        new_valid = 1'b1;
        new_byte  = '{dc: pin_s2_r.dcs,
                      data: {shift_r, pin_s2_r.d[lhi_pkg::PIN_SI]}};
      end
    end
    // a partial byte is dropped when the host lets go of select
    if (!sel_now) begin
      bit_cnt_nxt = lhi_pkg::SER_FIRST;
    end
    if (in_init) begin
      shift_nxt   = '0;
      bit_cnt_nxt = lhi_pkg::SER_FIRST;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      shift_r   <= '0;
      bit_cnt_r <= lhi_pkg::SER_FIRST;
    end else begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // ==========================================================
  // hand-off into the fifo
  logic               ctrl_busy_r, ctrl_busy_nxt;
  logic               pend_valid_r, pend_valid_nxt;
  lhi_pkg::lhi_byte_t pend_r, pend_nxt;
  logic               ovf_r, ovf_nxt;
  logic               refused_r, refused_nxt;
  logic               fifo_in_ready, fifo_out_valid, fifo_out_ready;
  lhi_pkg::lhi_byte_t fifo_out;
  logic               take_byte, refuse_byte, clr_ovf, clr_refused;

  lhi_fifo #(
    .WIDTH ($bits(lhi_pkg::lhi_byte_t)),
    .DEPTH (lhi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .in_valid  (pend_valid_r),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // the pin host cannot be stalled: one byte waits here, a second one
  // arriving while the fifo stays full is lost and flagged
  always_comb begin
    refuse_byte    = new_valid && !new_byte.dc && ctrl_busy_r;
    take_byte      = new_valid && !refuse_byte;
    pend_valid_nxt = pend_valid_r && !fifo_in_ready;
    pend_nxt       = pend_r;
    ovf_nxt        = ovf_r && !clr_ovf;
    refused_nxt    = refused_r && !clr_refused;
    if (take_byte) begin
      if (pend_valid_nxt) begin
        ovf_nxt = 1'b1;
      end else begin
        pend_valid_nxt = 1'b1;
        pend_nxt       = new_byte;
      end
    end
    if (refuse_byte) begin
      refused_nxt = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_valid_r <= 1'b0;
      pend_r       <= '0;
      ovf_r        <= 1'b0;
      refused_r    <= 1'b0;
    end else begin
      pend_valid_r <= pend_valid_nxt;
      pend_r       <= pend_nxt;
      ovf_r        <= ovf_nxt;
      refused_r    <= refused_nxt;
    end
  end

  // ==========================================================
  // data pin drivers
  logic [7:0] rdd_r, rdd_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic [7:0] doe_n_r, doe_n_nxt;

  always_comb begin
    dout_nxt  = lhi_pkg::BYTE_ZERO;
    doe_n_nxt = '1;
    if (read_active) begin
      doe_n_nxt = '0;
      dout_nxt  = pin_s2_r.dcs ? rdd_r
                               : {ctrl_busy_r, lhi_pkg::STATUS_LOW};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dout_r  <= lhi_pkg::BYTE_ZERO;
      doe_n_r <= '1;
    end else begin
      dout_r  <= dout_nxt;
      doe_n_r <= doe_n_nxt;
    end
  end

  assign DATA_OUT  = dout_r;
  assign DATA_OE_N = doe_n_r;

  // ==========================================================
  // axi4-lite slave
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        do_wr, ar_hs;

  always_comb begin
    aw_hold_nxt   = aw_hold_r || (S_AXI_AWVALID && awready_r);
    w_hold_nxt    = w_hold_r || (S_AXI_WVALID && wready_r);
    awaddr_nxt    = (S_AXI_AWVALID && awready_r) ? S_AXI_AWADDR : awaddr_r;
    wdata_nxt     = (S_AXI_WVALID && wready_r) ? S_AXI_WDATA : wdata_r;
    wstrb0_nxt    = (S_AXI_WVALID && wready_r) ? S_AXI_WSTRB[0] : wstrb0_r;
    bvalid_nxt    = bvalid_r && !S_AXI_BREADY;
    bresp_nxt     = bresp_r;
    ctrl_busy_nxt = ctrl_busy_r;
    rdd_nxt       = rdd_r;
    clr_ovf       = 1'b0;
    clr_refused   = 1'b0;
    do_wr         = aw_hold_r && w_hold_r && !bvalid_r;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = reg_hit(awaddr_r) ? lhi_pkg::RESP_OKAY : lhi_pkg::RESP_SLVERR;
      if (wstrb0_r && awaddr_r == lhi_pkg::ADDR_CTRL) begin
        ctrl_busy_nxt = wdata_r[lhi_pkg::CTRL_BUSY];
      end
      if (wstrb0_r && awaddr_r == lhi_pkg::ADDR_RDD) begin
        rdd_nxt = wdata_r[lhi_pkg::BYTE_W-1:0];
      end
      if (wstrb0_r && awaddr_r == lhi_pkg::ADDR_STAT) begin
        clr_ovf     = wdata_r[lhi_pkg::STAT_OVF];
        clr_refused = wdata_r[lhi_pkg::STAT_REFUSED];
      end
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;

    ar_hs          = S_AXI_ARVALID && arready_r;
    rvalid_nxt     = rvalid_r && !S_AXI_RREADY;
    rdata_nxt      = rdata_r;
    rresp_nxt      = rresp_r;
    fifo_out_ready = 1'b0;
    if (ar_hs) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = '0;
      rresp_nxt  = reg_hit(S_AXI_ARADDR) ? lhi_pkg::RESP_OKAY : lhi_pkg::RESP_SLVERR;
      unique case (S_AXI_ARADDR)
        lhi_pkg::ADDR_CTRL: rdata_nxt[lhi_pkg::CTRL_BUSY] = ctrl_busy_r;
        lhi_pkg::ADDR_STAT: begin
          rdata_nxt[lhi_pkg::STAT_NEMPTY]   = fifo_out_valid;
          rdata_nxt[lhi_pkg::STAT_OVF]      = ovf_r;
          rdata_nxt[lhi_pkg::STAT_REFUSED]  = refused_r;
          rdata_nxt[lhi_pkg::STAT_STYLE68]  = style68;
          rdata_nxt[lhi_pkg::STAT_PARALLEL] = parallel;
          rdata_nxt[lhi_pkg::STAT_INIT]     = in_init;
        end
        lhi_pkg::ADDR_RXD: begin
          rdata_nxt[lhi_pkg::BYTE_W-1:0] = fifo_out.data;
          rdata_nxt[lhi_pkg::RXD_DC]    = fifo_out.dc;
          rdata_nxt[lhi_pkg::RXD_VALID] = fifo_out_valid;
          fifo_out_ready                = fifo_out_valid;
        end
        lhi_pkg::ADDR_RDD: rdata_nxt[lhi_pkg::BYTE_W-1:0] = rdd_r;
        default: rdata_nxt = '0;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_hold_r   <= 1'b0;
      w_hold_r    <= 1'b0;
      awaddr_r    <= '0;
      wdata_r     <= '0;
      wstrb0_r    <= 1'b0;
      awready_r   <= 1'b0;
      wready_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= lhi_pkg::RESP_OKAY;
      arready_r   <= 1'b0;
      rvalid_r    <= 1'b0;
      rresp_r     <= lhi_pkg::RESP_OKAY;
      rdata_r     <= '0;
      ctrl_busy_r <= 1'b0;
      rdd_r       <= lhi_pkg::BYTE_ZERO;
    end else begin
      aw_hold_r   <= aw_hold_nxt;
      w_hold_r    <= w_hold_nxt;
      awaddr_r    <= awaddr_nxt;
      wdata_r     <= wdata_nxt;
      wstrb0_r    <= wstrb0_nxt;
      awready_r   <= awready_nxt;
      wready_r    <= wready_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      arready_r   <= arready_nxt;
      rvalid_r    <= rvalid_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
      ctrl_busy_r <= ctrl_busy_nxt;
      rdd_r       <= rdd_nxt;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY  = wready_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RRESP   = rresp_r;
  assign S_AXI_RDATA   = rdata_r;

endmodule

// file: test/lhi_host_port_properties.sv
// Purpose: pin and bus properties of the lcd host port
// Assumes: pins held >= 6 clk; sync flops plus output register lag < 6 clk
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module lhi_host_port_properties (
  // clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RESET_N,
  // host pins
  input wire logic       CHIP_SELECT_N,
  input wire logic       DATA_COMMAND_SELECT,
  input wire logic       WRITE_STROBE_N,
  input wire logic       READ_STROBE_N,
  input wire logic       BUS_STYLE_SELECT,
  input wire logic       PARALLEL_SELECT,
  input wire logic       HARD_INIT_N,
  input wire logic [7:0] DATA_OUT,
  input wire logic [7:0] DATA_OE_N,
  // bus handshakes
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_BREADY,
  input wire logic       S_AXI_RVALID,
  input wire logic       S_AXI_RREADY
);
  // ==========================================================
  // read cycle decode
  logic rd_act;
  assign rd_act = PARALLEL_SELECT && !CHIP_SELECT_N && HARD_INIT_N &&
                  (BUS_STYLE_SELECT ? READ_STROBE_N && WRITE_STROBE_N : !READ_STROBE_N);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // long holds so sync latency never makes these fire early
  sequence s_rd80; (rd_act && !BUS_STYLE_SELECT) [*7]; endsequence
  sequence s_rd68; (rd_act && BUS_STYLE_SELECT) [*7]; endsequence
  sequence s_idle; (!rd_act) [*6]; endsequence
  // ==========================================================
  // properties
  a_read80_drives: assert property (s_rd80 |-> DATA_OE_N == 8'h00)
    else $error("80 read left pins undriven");
  a_read68_drives: assert property (s_rd68 |-> DATA_OE_N == 8'h00)
    else $error("68 read left pins undriven");
  a_read_release: assert property (s_idle |-> DATA_OE_N == 8'hFF)
    else $error("pins driven outside a read");
  a_serial_no_drive: assert property ((!PARALLEL_SELECT) [*6] |-> DATA_OE_N == 8'hFF)
    else $error("serial mode drove pins");
  a_cs_no_drive: assert property (CHIP_SELECT_N [*6] |-> DATA_OE_N == 8'hFF)
    else $error("pins driven while deselected");
  a_init_no_drive: assert property ((!HARD_INIT_N) [*6] |-> DATA_OE_N == 8'hFF)
    else $error("pins driven during init");
  a_write68_quiet: assert property ((PARALLEL_SELECT && BUS_STYLE_SELECT &&
    !CHIP_SELECT_N && !WRITE_STROBE_N) [*6] |-> DATA_OE_N == 8'hFF)
    else $error("68 write direction drove pins");
  a_status_low_zero: assert property ((rd_act && !DATA_COMMAND_SELECT) [*7] |->
    DATA_OUT[6:0] == 7'h00)
    else $error("status low bits not zero");
  a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_rvalid_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response repeated");
endmodule

// file: test/lhi_host_model.sv
// Purpose: host microprocessor model on the lcd port pins
// Assumes: pins change by non-blocking assignment right after clk rises
// Notes:   every level held >= 4 clk so the port synchronizers see it
`timescale 1ns/1ps
module lhi_host_model (
  // clock and resolved pins
  input  wire logic       clk,
  input  wire logic [7:0] pin,
  // host outputs
  output logic            cs_n,
  output logic            dcs,
  output logic            wr_n,
  output logic            rd_n,
  output logic            sty,
  output logic            par,
  output logic            init_n,
  output logic [7:0]      d
);
  initial begin
    cs_n = 1'b1;
    dcs = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    sty = 1'b0;
    par = 1'b1;
    init_n = 1'b1;
    d = 8'h00;
  end
  task automatic st(input int n);
    repeat (n) @(posedge clk);
  endtask
  // straps; 68 idle keeps the enable low
  task automatic mode(input logic s, input logic p);
    sty <= s;
    par <= p;
    rd_n <= !s;
    wr_n <= 1'b1;
    st(4);
  endtask
  task automatic hold(input logic v);
    init_n <= v;
    st(6);
  endtask
  task automatic wr(input logic dc, input logic [7:0] b);
    cs_n <= 1'b0;
    dcs <= dc;
    d <= b;
    wr_n <= !sty;
    st(4);
    if (sty) rd_n <= 1'b1;
    else wr_n <= 1'b0;
    st(4);
    if (sty) rd_n <= 1'b0;
    else wr_n <= 1'b1;
    st(4);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    st(4);
  endtask
  task automatic rd(input logic dc, output logic [7:0] b);
    cs_n <= 1'b0;
    dcs <= dc;
    // released lines must not keep the last value
    d <= ~d;
    rd_n <= sty;
    st(8);
    b = pin;
    rd_n <= !sty;
    st(4);
    cs_n <= 1'b1;
    st(4);
  endtask
  // clock stands low outside frames
  task automatic ser(input logic dc, input logic [7:0] b, input int n, input logic rel);
    cs_n <= 1'b0;
    dcs <= dc;
    st(5);
    for (int i = 7; i > 7 - n; i--) begin
      d[7] <= b[i];
      st(5);
      d[6] <= 1'b1;
      st(5);
      d[6] <= 1'b0;
    end
    st(5);
    cs_n <= rel;
    st(5);
  endtask
endmodule

// file: test/lhi_host_port_tb.sv
// Purpose: self-checking bench of the lcd host port
// Assumes: host model on the pins, AXI4-Lite master tasks here
// Notes:   fifo fill uses 16 entries + output register + one pending byte
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module lhi_host_port_tb;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0]  dout, oe_n, hd, pin, b;
  logic        cs_n, dcs, wr_n, rd_n, sty, par, init_n;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, br, rr;
  logic [31:0] rdata, v;
  int          error_cnt = 0;
  int          comparisons = 0;
  always #4 core_clk = ~core_clk;
  assign pin = (~oe_n & dout) | (oe_n & hd);
  lhi_host_port i_lhi_host_port (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .CHIP_SELECT_N(cs_n),
    .DATA_COMMAND_SELECT(dcs), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n),
    .BUS_STYLE_SELECT(sty), .PARALLEL_SELECT(par), .HARD_INIT_N(init_n),
    .DATA_IN(pin), .DATA_OUT(dout), .DATA_OE_N(oe_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  lhi_host_model i_host (
    .clk(core_clk), .pin(pin), .cs_n(cs_n), .dcs(dcs), .wr_n(wr_n), .rd_n(rd_n),
    .sty(sty), .par(par), .init_n(init_n), .d(hd));
  // ==========================================================
  // bus tasks
  task automatic end_sim();
    $display("%0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      br = bresp;
      n++;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    @(posedge core_clk);
    if (n >= 100) begin error_cnt++; end_sim(); end
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arv <= 1'b0;
      v = rdata;
      rr = rresp;
      n++;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    @(posedge core_clk);
    if (n >= 100) begin error_cnt++; end_sim(); end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    axr(lhi_pkg::ADDR_CTRL);
    `CHK(v, 32'h0000_0000)
    axr(lhi_pkg::ADDR_STAT);
    `CHK(v, 32'h0000_0010)
    axr(8'h10);
    `CHK(rr, lhi_pkg::RESP_SLVERR)
    axw(8'h10, 32'hFFFF_FFFF);
    `CHK(br, lhi_pkg::RESP_SLVERR)
    axw(lhi_pkg::ADDR_RDD, 32'h0000_00A5);
    axr(lhi_pkg::ADDR_RDD);
    `CHK(v, 32'h0000_00A5)
    $display("test regs done");
  endtask
  task automatic t_par80();
    i_host.wr(1'b1, 8'h3C);
    i_host.wr(1'b0, 8'hC3);
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v, 32'h8000_013C)
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v, 32'h8000_00C3)
    i_host.rd(1'b1, b);
    `CHK(b, 8'hA5)
    axw(lhi_pkg::ADDR_CTRL, 32'h0000_0001);
    i_host.rd(1'b0, b);
    `CHK(b, 8'h80)
    i_host.wr(1'b0, 8'h11);
    i_host.wr(1'b1, 8'h22);
    axr(lhi_pkg::ADDR_STAT);
    `CHK(v, 32'h0000_0015)
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v, 32'h8000_0122)
    axw(lhi_pkg::ADDR_STAT, 32'h0000_0004);
    axw(lhi_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test par80 done");
  endtask
  task automatic t_par68();
    i_host.mode(1'b1, 1'b1);
    axr(lhi_pkg::ADDR_STAT);
    `CHK(v, 32'h0000_0018)
    i_host.wr(1'b1, 8'h5A);
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v, 32'h8000_015A)
    i_host.rd(1'b1, b);
    `CHK(b, 8'hA5)
    $display("test par68 done");
  endtask
  task automatic t_serial();
    i_host.mode(1'b0, 1'b0);
    i_host.ser(1'b1, 8'h96, 8, 1'b1);
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v, 32'h8000_0196)
    i_host.ser(1'b0, 8'hFF, 3, 1'b1);
    i_host.ser(1'b0, 8'h81, 8, 1'b1);
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v, 32'h8000_0081)
    i_host.ser(1'b0, 8'hFF, 3, 1'b0);
    i_host.hold(1'b0);
    axr(lhi_pkg::ADDR_STAT);
    `CHK(v, 32'h0000_0020)
    i_host.hold(1'b1);
    i_host.ser(1'b1, 8'h42, 8, 1'b1);
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v, 32'h8000_0142)
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v[31], 1'b0)
    $display("test serial done");
  endtask
  task automatic t_fill();
    i_host.mode(1'b0, 1'b1);
    for (int i = 0; i < 19; i++) i_host.wr(1'b1, 8'(i));
    axr(lhi_pkg::ADDR_STAT);
    `CHK(v, 32'h0000_0013)
    for (int i = 0; i < 18; i++) begin
      axr(lhi_pkg::ADDR_RXD);
      `CHK(v, {24'h80_0001, 8'(i)})
    end
    axr(lhi_pkg::ADDR_RXD);
    `CHK(v[31], 1'b0)
    $display("test fill done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_par80();
    t_par68();
    t_serial();
    t_fill();
    end_sim();
  end
endmodule
bind lhi_host_port lhi_host_port_properties i_lhi_host_port_properties (.*);
